// ==== hdl/crre_exec.sv ====
// Executor for clear-carry, subroutine return and rotate-left
// Overview of operation
// - Clear-carry forces the carry flag to zero whatever it held before.
// - Clear-carry is the one-byte opcode CF, runs 4 cycles and leaves all other flags alone.
// - Return loads the program counter from the stack at the stack pointer and then adds 2 to the stack pointer.
// - After return, fetch continues at the address in the freshly loaded program counter.
// - Return is the one-byte opcode AF, runs 8 cycles and changes no condition flag.
// - Rotate-left shifts the operand up one bit and puts old bit 7 into bit 0 and into carry.
// - Rotate-left is two bytes and 4 cycles, opcode 90 direct and opcode 91 indirect through a register.
// - Rotate-left sets carry when the bit leaving bit 7 was 1 and clears it otherwise.
// - Rotate-left sets zero on an all-zero result, copies result bit 7 to sign, keeps decimal-adjust and half-carry.
// - Rotate-left sets overflow when the sign bit changed during rotation and clears it otherwise.
module crre_exec (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Instruction issue
  input  wire logic                  instr_valid,
  input  wire logic [7:0]            instr_opcode,
  input  wire logic [7:0]            instr_operand,
  output logic                       busy,
  output logic                       done,
  // Register file read port, data returned in the same cycle
  output logic                       rd_en,
  output logic      [7:0]            rd_addr,
  input  wire logic [7:0]            rd_data,
  // Register file write port
  output crre_pkg::crre_wr_t         wr,
  // Core state
  output crre_pkg::crre_flags_t      flags,
  output logic      [7:0]            stack_pointer,
  output logic      [15:0]           program_counter,
  // Instruction fetch
  output logic                       fetch_go,
  output logic      [15:0]           fetch_addr
);

  typedef enum logic {
    CRRE_IDLE,
    CRRE_EXEC
  } crre_state_t;

  // Opcode is one the block executes
  function automatic logic is_known(input logic [7:0] opc);
    is_known = (opc == crre_pkg::OPC_CLEAR_CARRY) || (opc == crre_pkg::OPC_RETURN) ||
               (opc == crre_pkg::OPC_ROTL_DIRECT) || (opc == crre_pkg::OPC_ROTL_INDIR);
  endfunction : is_known

  // Index of the last cycle of an instruction
  function automatic logic [3:0] last_cycle(input logic [7:0] opc);
    case (opc)
      crre_pkg::OPC_RETURN:      last_cycle = crre_pkg::CYC_RETURN - 4'h1;
      crre_pkg::OPC_CLEAR_CARRY: last_cycle = crre_pkg::CYC_CLEAR_CARRY - 4'h1;
      default:                   last_cycle = crre_pkg::CYC_ROTL - 4'h1;
    endcase
  endfunction : last_cycle

  crre_state_t           state_q;
  logic [3:0]            cnt_q;
  logic [7:0]            opc_q;
  logic [7:0]            operand_q;
  logic [7:0]            rd_addr_q;
  crre_pkg::crre_wr_t    wr_q;
  crre_pkg::crre_flags_t flags_q;
  logic [7:0]            stack_ptr_q;
  logic [15:0]           prog_cnt_q;
  logic                  fetch_go_q;
  logic                  accept;
  logic                  is_rtn;
  logic                  is_clr;
  logic                  is_rdir;
  logic                  is_rind;
  logic                  rot_now;
  logic [7:0]            rot_result;
  crre_pkg::crre_flags_t rot_flags;

  assign accept  = (state_q == CRRE_IDLE) && instr_valid && is_known(instr_opcode);
  assign busy    = (state_q == CRRE_EXEC);
  assign done    = busy && (cnt_q == last_cycle(opc_q));
  assign is_rtn  = (opc_q == crre_pkg::OPC_RETURN);
  assign is_clr  = (opc_q == crre_pkg::OPC_CLEAR_CARRY);
  assign is_rdir = (opc_q == crre_pkg::OPC_ROTL_DIRECT);
  assign is_rind = (opc_q == crre_pkg::OPC_ROTL_INDIR);
  // Operand byte arrives in cycle 0 when direct, cycle 1 when fetched through a pointer
  assign rot_now = busy && ((is_rdir && cnt_q == crre_pkg::CNT_FIRST) ||
                            (is_rind && cnt_q == crre_pkg::CNT_SECOND));
  assign rd_en   = busy && ((is_rtn || is_rind) ? (cnt_q <= crre_pkg::CNT_SECOND)
                                                : (is_rdir && cnt_q == crre_pkg::CNT_FIRST));
  assign rd_addr = rd_addr_q;

  assign wr              = wr_q;
  assign flags           = flags_q;
  assign stack_pointer   = stack_ptr_q;
  assign program_counter = prog_cnt_q;
  assign fetch_go        = fetch_go_q;
  assign fetch_addr      = prog_cnt_q;

  crre_rotl_alu u_rotl (
    .operand   (rd_data),
    .flags_in  (flags_q),
    .result    (rot_result),
    .flags_out (rot_flags)
  );

  // Sequencing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= CRRE_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        CRRE_IDLE: begin
          cnt_q <= 4'h0;
          if (accept) begin
            state_q <= CRRE_EXEC;
          end
        end
        CRRE_EXEC: begin
          if (done) begin
            state_q <= CRRE_IDLE;
            cnt_q   <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= CRRE_IDLE;
          cnt_q   <= 4'h0;
        end
      endcase
    end
  end

  // Captured instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opc_q     <= 8'h00;
      operand_q <= 8'h00;
    end else if (accept) begin
      opc_q     <= instr_opcode;
      operand_q <= instr_operand;
    end
  end

  // Read address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_addr_q <= 8'h00;
    end else if (accept) begin
      rd_addr_q <= (instr_opcode == crre_pkg::OPC_RETURN) ? stack_ptr_q : instr_operand;
    end else if (busy && cnt_q == crre_pkg::CNT_FIRST) begin
      if (is_rtn) begin
        rd_addr_q <= stack_ptr_q + crre_pkg::STACK_NEXT_BYTE;
      end else if (is_rind) begin
        rd_addr_q <= rd_data;
      end
    end
  end

  // Register file write of the rotated byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
    end else begin
      wr_q.en <= rot_now;
      if (rot_now) begin
        wr_q.addr <= is_rdir ? operand_q : rd_addr_q;
        wr_q.data <= rot_result;
      end
    end
  end

  // Condition flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= crre_pkg::FLAGS_RESET;
    end else if (rot_now) begin
      flags_q <= rot_flags;
    end else if (busy && is_clr && cnt_q == crre_pkg::CNT_FIRST) begin
      flags_q.c <= 1'b0;
    end
  end

  // Stack pointer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stack_ptr_q <= crre_pkg::STACK_PTR_RESET;
    end else if (busy && is_rtn && cnt_q == crre_pkg::CNT_SECOND) begin
      stack_ptr_q <= stack_ptr_q + crre_pkg::STACK_RETURN_STEP;
    end
  end

  // Program counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_cnt_q <= crre_pkg::PROG_CNT_RESET;
    end else if (busy && is_rtn && cnt_q == crre_pkg::CNT_FIRST) begin
      prog_cnt_q[15:8] <= rd_data;
    end else if (busy && is_rtn && cnt_q == crre_pkg::CNT_SECOND) begin
      prog_cnt_q[7:0] <= rd_data;
    end else if (done && is_clr) begin
      prog_cnt_q <= prog_cnt_q + crre_pkg::LEN_CLEAR_CARRY;
    end else if (done && !is_rtn) begin
      prog_cnt_q <= prog_cnt_q + crre_pkg::LEN_ROTL;
    end
  end

  // Fetch strobe after each instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_go_q <= 1'b0;
    end else begin
      fetch_go_q <= done;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_rtn_start;
    accept && instr_opcode == crre_pkg::OPC_RETURN;
  endsequence

  sequence s_rtn_bytes;
    busy && is_rtn && cnt_q == crre_pkg::CNT_FIRST ##1 busy && is_rtn && cnt_q == crre_pkg::CNT_SECOND;
  endsequence

  a_carry_clear: assert property (
    busy && is_clr && cnt_q == crre_pkg::CNT_FIRST |=> !flags_q.c)
    else $error("carry not cleared");

  a_clear_others: assert property (
    busy && is_clr |=> flags_q.z == $past(flags_q.z) && flags_q.s == $past(flags_q.s) &&
                       flags_q.v == $past(flags_q.v) && flags_q.d == $past(flags_q.d) &&
                       flags_q.h == $past(flags_q.h))
    else $error("clear carry touched another flag");

  a_clear_length: assert property (
    accept && instr_opcode == crre_pkg::OPC_CLEAR_CARRY |=> !done [*3] ##1 done)
    else $error("clear carry length wrong");

  a_rtn_counter_load: assert property (
    s_rtn_bytes |=> prog_cnt_q == {$past(rd_data, 2), $past(rd_data)})
    else $error("return loaded wrong program counter");

  a_rtn_stack_step: assert property (
    s_rtn_start |=> ##2 stack_ptr_q == $past(stack_ptr_q, 3) + crre_pkg::STACK_RETURN_STEP)
    else $error("return stack pointer step wrong");

  a_rtn_stack_addr: assert property (
    s_rtn_start |=> rd_en && rd_addr == $past(stack_ptr_q) ##1
                    rd_en && rd_addr == $past(stack_ptr_q, 2) + crre_pkg::STACK_NEXT_BYTE)
    else $error("return read wrong stack address");

  a_rtn_length: assert property (
    s_rtn_start |=> !done [*7] ##1 done)
    else $error("return length wrong");

  a_rtn_flags: assert property (
    busy && is_rtn |=> flags_q == $past(flags_q))
    else $error("return changed a flag");

  a_rtn_fetch: assert property (
    done && is_rtn |=> fetch_go && fetch_addr == $past(prog_cnt_q))
    else $error("fetch not at returned address");

  a_rtn_resume: assert property (
    s_rtn_bytes |=> ##6 fetch_go && fetch_addr == {$past(rd_data, 8), $past(rd_data, 7)})
    else $error("fetch after return not at popped address");

  a_clear_advance: assert property (
    done && is_clr |=> prog_cnt_q == $past(prog_cnt_q) + crre_pkg::LEN_CLEAR_CARRY)
    else $error("clear carry program counter step wrong");

  a_rot_advance: assert property (
    done && (is_rdir || is_rind) |=> prog_cnt_q == $past(prog_cnt_q) + crre_pkg::LEN_ROTL)
    else $error("rotate program counter step wrong");

  a_rot_waddr: assert property (
    rot_now |=> wr.addr == $past(rd_addr))
    else $error("rotate written to wrong register");

  a_unknown_ignored: assert property (
    !busy && instr_valid && !is_known(instr_opcode) |=> !busy)
    else $error("unknown opcode accepted");

  a_rot_data: assert property (
    rot_now |=> wr.en && wr.data == {$past(rd_data[6:0]), $past(rd_data[7])})
    else $error("rotate result wrong");

  a_rot_length: assert property (
    accept && instr_opcode[7:1] == crre_pkg::OPC_ROTL_DIRECT[7:1] |=> !done [*3] ##1 done)
    else $error("rotate length wrong");

  a_rot_carry: assert property (
    rot_now |=> flags_q.c == $past(rd_data[7]))
    else $error("rotate carry wrong");

  a_rot_zero_sign: assert property (
    rot_now |=> flags_q.z == ($past(rd_data) == 8'h00) && flags_q.s == $past(rd_data[6]) &&
                flags_q.d == $past(flags_q.d) && flags_q.h == $past(flags_q.h))
    else $error("rotate zero sign or kept flags wrong");

  a_rot_overflow: assert property (
    rot_now |=> flags_q.v == ($past(rd_data[7]) ^ $past(rd_data[6])))
    else $error("rotate overflow wrong");

endmodule : crre_exec

// ==== hdl/crre_pkg.sv ====
// Package: opcodes, cycle counts, reset values and flag layout of the executor
package crre_pkg;

  // Opcodes handled by the block
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'hCF;
  localparam logic [7:0] OPC_RETURN      = 8'hAF;
  localparam logic [7:0] OPC_ROTL_DIRECT = 8'h90;
  localparam logic [7:0] OPC_ROTL_INDIR  = 8'h91;

  // Cycles taken by each instruction
  localparam logic [3:0] CYC_CLEAR_CARRY = 4'h4;
  localparam logic [3:0] CYC_RETURN      = 4'h8;
  localparam logic [3:0] CYC_ROTL        = 4'h4;

  // Instruction lengths in bytes
  localparam logic [15:0] LEN_CLEAR_CARRY = 16'h0001;
  localparam logic [15:0] LEN_ROTL        = 16'h0002;

  // Stack pointer step on return and address offset of the second stack byte
  localparam logic [7:0] STACK_RETURN_STEP = 8'h02;
  localparam logic [7:0] STACK_NEXT_BYTE   = 8'h01;

  // Cycle positions inside an instruction
  localparam logic [3:0] CNT_FIRST  = 4'h0;
  localparam logic [3:0] CNT_SECOND = 4'h1;

  // Values after reset
  localparam logic [15:0] PROG_CNT_RESET  = 16'h0000;
  localparam logic [7:0]  STACK_PTR_RESET = 8'h00;

  // Condition flags
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } crre_flags_t;

  localparam crre_flags_t FLAGS_RESET = '0;

  // Register file write request
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } crre_wr_t;

endpackage : crre_pkg

// ==== hdl/crre_rotl_alu.sv ====
// Rotate-left data path with flag generation
module crre_rotl_alu (
  // Operand and incoming flags
  input  wire logic [7:0]           operand,
  input  wire crre_pkg::crre_flags_t flags_in,
  // Result and outgoing flags
  output logic      [7:0]           result,
  output crre_pkg::crre_flags_t     flags_out
);

  always_comb begin
    result      = {operand[6:0], operand[7]};
    flags_out   = flags_in;
    flags_out.c = operand[7];
    flags_out.z = (result == 8'h00);
    flags_out.s = result[7];
    flags_out.v = operand[7] ^ result[7];
  end

endmodule : crre_rotl_alu

// ==== tb/testbench.sv ====
// Self-checking bench for the clear-carry, return and rotate-left executor
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  sys_clk;
  logic                  rst;
  logic                  instr_valid;
  logic [7:0]            instr_opcode;
  logic [7:0]            instr_operand;
  logic                  busy;
  logic                  done;
  logic                  rd_en;
  logic [7:0]            rd_addr;
  logic [7:0]            rd_data;
  crre_pkg::crre_wr_t    wr;
  crre_pkg::crre_flags_t flags;
  logic [7:0]            stack_pointer;
  logic [15:0]           program_counter;
  logic                  fetch_go;
  logic [15:0]           fetch_addr;
  // Bench model state
  logic [7:0]            rf [256];
  crre_pkg::crre_flags_t mf;
  logic [15:0]           mpc;
  logic [7:0]            msp;
  int                    n_mismatch;
  int                    n_tests;

  crre_exec uut (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .instr_valid     (instr_valid),
    .instr_opcode    (instr_opcode),
    .instr_operand   (instr_operand),
    .busy            (busy),
    .done            (done),
    .rd_en           (rd_en),
    .rd_addr         (rd_addr),
    .rd_data         (rd_data),
    .wr              (wr),
    .flags           (flags),
    .stack_pointer   (stack_pointer),
    .program_counter (program_counter),
    .fetch_go        (fetch_go),
    .fetch_addr      (fetch_addr)
  );

  // Register file with combinational read
  assign rd_data = rf[rd_addr];
  always @(posedge sys_clk) begin
    if (wr.en === 1'b1) begin
      rf[wr.addr] <= wr.data;
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Issue one instruction and check timing and core state
  task automatic run(input logic [7:0] op, input logic [7:0] arg, input int ncyc);
    int k;
    instr_valid   = 1'b1;
    instr_opcode  = op;
    instr_operand = arg;
    @(posedge sys_clk);
    #2;
    instr_valid = 1'b0;
    `CHK("busy", busy, 1'b1)
    `CHK("rd_en", rd_en, (op != crre_pkg::OPC_CLEAR_CARRY))
    k = 1;
    while (done !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #2;
      k++;
    end
    if (k >= 20) begin
      n_mismatch++;
      finish_test();
    end
    `CHK("cycles", k, ncyc)
    @(posedge sys_clk);
    #2;
    `CHK("fetch_go", fetch_go, 1'b1)
    `CHK("fetch_addr", fetch_addr, mpc)
    `CHK("program_counter", program_counter, mpc)
    `CHK("stack_pointer", stack_pointer, msp)
    `CHK("flags", flags, mf)
    `CHK("busy_end", busy, 1'b0)
  endtask : run

  task automatic rot(input logic [7:0] op, input logic [7:0] a, input logic [7:0] v);
    logic [7:0] t;
    logic [7:0] r;
    t = (op == crre_pkg::OPC_ROTL_INDIR) ? (a ^ 8'h80) : a;
    if (op == crre_pkg::OPC_ROTL_INDIR) begin
      rf[a] = t;
    end
    rf[t] = v;
    r = {v[6:0], v[7]};
    mf.c = v[7];
    mf.z = (r == 8'h00);
    mf.s = r[7];
    mf.v = v[7] ^ v[6];
    mpc = mpc + 16'h0002;
    run(op, a, 4);
    `CHK("rot_result", rf[t], r)
  endtask : rot

  task automatic clr;
    mf.c = 1'b0;
    mpc = mpc + 16'h0001;
    run(crre_pkg::OPC_CLEAR_CARRY, 8'($urandom), 4);
  endtask : clr

  task automatic do_return;
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'($urandom);
    lo = 8'($urandom);
    rf[msp] = hi;
    rf[msp + 8'h01] = lo;
    mpc = {hi, lo};
    msp = msp + 8'h02;
    run(crre_pkg::OPC_RETURN, 8'h00, 8);
  endtask : do_return

  initial begin
    logic [7:0] vals [4];
    n_mismatch = 0;
    n_tests = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_operand = 8'h00;
    vals = '{8'hAA, 8'h00, 8'h40, 8'h80};
    for (int i = 0; i < 256; i++) begin
      rf[i] = 8'(i);
    end
    mf = '0;
    mpc = 16'h0000;
    msp = 8'h00;
    void'($urandom(32'h4820_1272));
    repeat (6) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    `CHK("reset_flags", flags, mf)
    `CHK("reset_program_counter", program_counter, mpc)
    // Edge values of the rotate, both addressing modes
    foreach (vals[i]) begin
      rot(crre_pkg::OPC_ROTL_DIRECT, 8'h10, vals[i]);
      rot(crre_pkg::OPC_ROTL_INDIR, 8'h21, vals[i]);
    end
    clr();
    do_return();
    // Random mix of all four opcodes
    for (int i = 0; i < 24; i++) begin
      case ($urandom % 4)
        0: clr();
        1: do_return();
        2: rot(crre_pkg::OPC_ROTL_DIRECT, 8'($urandom), 8'($urandom));
        default: rot(crre_pkg::OPC_ROTL_INDIR, 8'($urandom), 8'($urandom));
      endcase
    end
    // Unknown opcode is never accepted
    instr_valid = 1'b1;
    instr_opcode = 8'h10;
    repeat (3) begin
      @(posedge sys_clk);
      #2;
      `CHK("busy_unknown", busy, 1'b0)
    end
    instr_valid = 1'b0;
    finish_test();
  end
endmodule : testbench
